/* verilog/aosc_defines.vh */
// register map, field positions, reset values and timing constants
`ifndef AOSC_DEFINES_VH
`define AOSC_DEFINES_VH
`define AOSC_ADDR_W          7
`define AOSC_DATA_W          9
`define AOSC_REG_BUF         7'h01
`define AOSC_REG_PWR         7'h03
`define AOSC_REG_ATT         7'h28
`define AOSC_REG_BST         7'h31
`define AOSC_REG_SPKVOL      7'h36
`define AOSC_REG_MMXMUTE     7'h38
`define AOSC_REG_MOUTMUTE    7'h45
`define AOSC_REG_LIMBST      7'h19
`define AOSC_REG_SRATE       7'h07
`define AOSC_REG_TIEOFF      7'h50
`define AOSC_REG_INSW        7'h51
`define AOSC_REG_STATUS      7'h52
`define AOSC_BIT_REFBUF      2
`define AOSC_BIT_BSTBUF      8
`define AOSC_BIT_SPKMX       2
`define AOSC_BIT_MONOMX      3
`define AOSC_BIT_SPKP        5
`define AOSC_BIT_SPKN        6
`define AOSC_BIT_MONOOUT     7
`define AOSC_BIT_SPEAKER_ATTEN      1
`define AOSC_BIT_MONOATT     2
`define AOSC_BIT_SPEAKER_BOOST_SELECT      2
`define AOSC_BIT_MONOBST     3
`define AOSC_BIT_SPKMUTE     6
`define AOSC_BIT_MMXMUTE     6
`define AOSC_BIT_MOUTMUTE    4
`define AOSC_BIT_LIMEN       8
`define AOSC_BIT_HIZ         0
`define AOSC_RST_REG         9'h000
`define AOSC_BOOST_MAX       4'hc
`define AOSC_DEPOP_MS        250
`define AOSC_CLK_KHZ         40000
`define AOSC_SR_BASE_KHZ     48
`define AOSC_DEPOP_CYCLES    (`AOSC_DEPOP_MS * `AOSC_CLK_KHZ)
`endif

/* verilog/aosc_depop_timer.v */
// depop delay counter scaled by the sample-rate setting
`timescale 1ns/10ps
`default_nettype none
`include "aosc_defines.vh"
module aosc_depop_timer #(
    parameter CYC_W     = 24,
    parameter BASE_CYC  = `AOSC_DEPOP_CYCLES
) (
    // clock and reset
    input  wire             clk_in,
    input  wire             rst_n_in,
    // control
    input  wire             start_in,
    input  wire [2:0]       srate_in,
    // status
    output reg              done_out
);
    reg  [CYC_W-1:0] cnt_q;
    reg  [3:0]       pre_q;
    wire [3:0]       pre_top;
    // slower sample rates stretch each base tick
    assign pre_top = {1'b0, srate_in};
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_q    <= {CYC_W{1'b0}};
            pre_q    <= 4'h0;
            done_out <= 1'b0;
        end else if (start_in) begin
            cnt_q    <= {CYC_W{1'b0}};
            pre_q    <= 4'h0;
            done_out <= 1'b0;
        end else if (!done_out) begin
            if (pre_q >= pre_top) begin
                pre_q <= 4'h0;
                if (cnt_q >= BASE_CYC[CYC_W-1:0] - 1'b1)
                    done_out <= 1'b1;
                else
                    cnt_q <= cnt_q + 1'b1;
            end else begin
                pre_q <= pre_q + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* verilog/aosc_gain_boost.v */
// fixed or limiter-gated digital boost for one playback sample
`timescale 1ns/10ps
`default_nettype none
`include "aosc_defines.vh"
module aosc_gain_boost #(
    parameter W = 16
) (
    // clock and reset
    input  wire                clk_in,
    input  wire                rst_n_in,
    // control
    input  wire [3:0]          level_in,
    input  wire                lim_en_in,
    input  wire                below_thr_in,
    // sample
    input  wire                valid_in,
    input  wire signed [W-1:0] sample_in,
    output reg  signed [W-1:0] sample_out,
    output reg                 valid_out
);
    // linear gain per dB in Q8, 0..12 dB
    function [11:0] db_gain;
        input [3:0] db;
        begin
            case (db)
                4'h0: db_gain = 12'h100;
                4'h1: db_gain = 12'h11f;
                4'h2: db_gain = 12'h142;
                4'h3: db_gain = 12'h16a;
                4'h4: db_gain = 12'h196;
                4'h5: db_gain = 12'h1c7;
                4'h6: db_gain = 12'h1ff;
                4'h7: db_gain = 12'h23d;
                4'h8: db_gain = 12'h283;
                4'h9: db_gain = 12'h2d2;
                4'ha: db_gain = 12'h32a;
                4'hb: db_gain = 12'h38c;
                default: db_gain = 12'h3fb;
            endcase
        end
    endfunction
    wire [3:0]              eff_db;
    wire                    apply;
    wire signed [W+12:0]    prod;
    wire signed [W+4:0]     shr;
    assign eff_db = (level_in > `AOSC_BOOST_MAX) ? `AOSC_BOOST_MAX
                                                 : level_in;
    assign apply  = !lim_en_in || below_thr_in;
    assign prod   = sample_in * $signed({1'b0, db_gain(eff_db)});
    assign shr    = prod[W+12:8];
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            sample_out <= {W{1'b0}};
            valid_out  <= 1'b0;
        end else begin
            valid_out <= valid_in;
            if (valid_in) begin
                if (!apply)
                    sample_out <= sample_in;
                else if (shr > $signed({1'b0, {(W-1){1'b1}}}))
                    sample_out <= {1'b0, {(W-1){1'b1}}};
                else if (shr < $signed({1'b1, {(W-1){1'b0}}}))
                    sample_out <= {1'b1, {(W-1){1'b0}}};
                else
                    sample_out <= shr[W-1:0];
            end
        end
    end
endmodule
`default_nettype wire

/* verilog/aosc_top.v */
// output stage control: registers, gating, tie-off and depop timing
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "aosc_defines.vh"
module aosc_top #(
    parameter SAMPLE_W    = 16,
    parameter N_INPUTS    = 4,
    parameter DEPOP_CYC   = `AOSC_DEPOP_CYCLES
) (
    // clock and reset
    input  wire                       REF_CLK_IN,
    input  wire                       RST_N_IN,
    // register port
    input  wire [`AOSC_ADDR_W-1:0]    REG_ADDR_IN,
    input  wire [`AOSC_DATA_W-1:0]    REG_WDATA_IN,
    input  wire                       REG_WR_IN,
    input  wire                       REG_RD_IN,
    output reg  [`AOSC_DATA_W-1:0]    REG_RDATA_OUT,
    // playback samples
    input  wire                       PLAY_VALID_IN,
    input  wire signed [SAMPLE_W-1:0] PLAY_SAMPLE_IN,
    input  wire                       LIM_BELOW_THR_IN,
    output wire                       PLAY_VALID_OUT,
    output wire signed [SAMPLE_W-1:0] PLAY_SAMPLE_OUT,
    // speaker output controls
    output reg                        SPEAKER_PLUS_PIN_DRIVE_OUT,
    output reg                        SPEAKER_MINUS_PIN_DRIVE_OUT,
    output reg  [5:0]                 SPEAKER_VOLUME_OUT,
    output reg                        SPEAKER_ATTEN_OUT,
    output reg                        SPEAKER_BOOST_SELECT_OUT,
    output reg                        SPEAKER_PLUS_PIN_TIE_OUT,
    output reg                        SPEAKER_MINUS_PIN_TIE_OUT,
    output reg                        SPEAKER_TIE_HI_OUT,
    // mono output controls
    output reg                        MONO_OUTPUT_PIN_DRIVE_OUT,
    output reg                        MONO_ATTEN_OUT,
    output reg                        MONO_BOOST_SELECT_OUT,
    output reg                        MONO_OUTPUT_PIN_TIE_OUT,
    output reg                        MONO_TIE_HI_OUT,
    // tie-off resources
    output reg                        REF_TIEOFF_BUFFER_ON_OUT,
    output reg                        BOOSTED_TIEOFF_BUFFER_ON_OUT,
    output reg                        TIEOFF_HIGH_Z_OUT,
    output reg  [N_INPUTS-1:0]        INPUT_TIE_OUT,
    // depop status
    output wire                       DEPOP_DONE_OUT
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [`AOSC_DATA_W-1:0] buf_q;
    reg [`AOSC_DATA_W-1:0] pwr_q;
    reg [`AOSC_DATA_W-1:0] att_q;
    reg [`AOSC_DATA_W-1:0] bst_q;
    reg [`AOSC_DATA_W-1:0] spkvol_q;
    reg [`AOSC_DATA_W-1:0] mmx_q;
    reg [`AOSC_DATA_W-1:0] mono_output_pin_q;
    reg [`AOSC_DATA_W-1:0] lim_q;
    reg [2:0]              srate_q;
    reg                    hiz_q;
    reg [N_INPUTS-1:0]     insw_q;
    reg                    pwr_wr_q;
    wire                   depop_done;
    wire                   any_out_on;

    always @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            buf_q    <= `AOSC_RST_REG;
            pwr_q    <= `AOSC_RST_REG;
            att_q    <= `AOSC_RST_REG;
            bst_q    <= `AOSC_RST_REG;
            spkvol_q <= `AOSC_RST_REG;
            mmx_q    <= `AOSC_RST_REG;
            mono_output_pin_q   <= `AOSC_RST_REG;
            lim_q    <= `AOSC_RST_REG;
            srate_q  <= 3'h0;
            hiz_q    <= 1'b0;
            insw_q   <= {N_INPUTS{1'b0}};
            pwr_wr_q <= 1'b0;
        end else begin
            pwr_wr_q <= 1'b0;
            if (REG_WR_IN) begin
                if (REG_ADDR_IN == `AOSC_REG_BUF)
                    buf_q <= REG_WDATA_IN;
                else if (REG_ADDR_IN == `AOSC_REG_PWR) begin
                    pwr_q    <= REG_WDATA_IN;
                    pwr_wr_q <= 1'b1;
                end else if (REG_ADDR_IN == `AOSC_REG_ATT)
                    att_q <= REG_WDATA_IN;
                else if (REG_ADDR_IN == `AOSC_REG_BST)
                    bst_q <= REG_WDATA_IN;
                else if (REG_ADDR_IN == `AOSC_REG_SPKVOL)
                    spkvol_q <= REG_WDATA_IN;
                else if (REG_ADDR_IN == `AOSC_REG_MMXMUTE)
                    mmx_q <= REG_WDATA_IN;
                else if (REG_ADDR_IN == `AOSC_REG_MOUTMUTE)
                    mono_output_pin_q <= REG_WDATA_IN;
                else if (REG_ADDR_IN == `AOSC_REG_LIMBST)
                    lim_q <= REG_WDATA_IN;
                else if (REG_ADDR_IN == `AOSC_REG_SRATE)
                    srate_q <= REG_WDATA_IN[3:1];
                else if (REG_ADDR_IN == `AOSC_REG_TIEOFF)
                    hiz_q <= REG_WDATA_IN[`AOSC_BIT_HIZ];
                else if (REG_ADDR_IN == `AOSC_REG_INSW)
                    insw_q <= REG_WDATA_IN[N_INPUTS-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always @(posedge REF_CLK_IN) begin
        if (!RST_N_IN)
            REG_RDATA_OUT <= {`AOSC_DATA_W{1'b0}};
        else if (REG_RD_IN) begin
            if (REG_ADDR_IN == `AOSC_REG_BUF)
                REG_RDATA_OUT <= buf_q;
            else if (REG_ADDR_IN == `AOSC_REG_PWR)
                REG_RDATA_OUT <= pwr_q;
            else if (REG_ADDR_IN == `AOSC_REG_ATT)
                REG_RDATA_OUT <= att_q;
            else if (REG_ADDR_IN == `AOSC_REG_BST)
                REG_RDATA_OUT <= bst_q;
            else if (REG_ADDR_IN == `AOSC_REG_SPKVOL)
                REG_RDATA_OUT <= spkvol_q;
            else if (REG_ADDR_IN == `AOSC_REG_MMXMUTE)
                REG_RDATA_OUT <= mmx_q;
            else if (REG_ADDR_IN == `AOSC_REG_MOUTMUTE)
                REG_RDATA_OUT <= mono_output_pin_q;
            else if (REG_ADDR_IN == `AOSC_REG_LIMBST)
                REG_RDATA_OUT <= lim_q;
            else if (REG_ADDR_IN == `AOSC_REG_SRATE)
                REG_RDATA_OUT <= {5'h00, srate_q, 1'b0};
            else if (REG_ADDR_IN == `AOSC_REG_TIEOFF)
                REG_RDATA_OUT <= {8'h00, hiz_q};
            else if (REG_ADDR_IN == `AOSC_REG_INSW)
                REG_RDATA_OUT <= {{(`AOSC_DATA_W-N_INPUTS){1'b0}}, insw_q};
            else if (REG_ADDR_IN == `AOSC_REG_STATUS)
                REG_RDATA_OUT <= {4'h0, INPUT_TIE_OUT == {N_INPUTS{1'b1}},
                                  MONO_OUTPUT_PIN_TIE_OUT,
                                  SPEAKER_MINUS_PIN_TIE_OUT,
                                  SPEAKER_PLUS_PIN_TIE_OUT, depop_done};
            else
                REG_RDATA_OUT <= {`AOSC_DATA_W{1'b0}};
        end else
            REG_RDATA_OUT <= {`AOSC_DATA_W{1'b0}};
    end

    // ------------------------------------------------------------
    // path gating and tie-off classification
    // ------------------------------------------------------------
    wire spk_mx  = pwr_q[`AOSC_BIT_SPKMX];
    wire spk_p   = pwr_q[`AOSC_BIT_SPKP];
    wire spk_n   = pwr_q[`AOSC_BIT_SPKN];
    wire mono_mx = pwr_q[`AOSC_BIT_MONOMX];
    wire mono_on = pwr_q[`AOSC_BIT_MONOOUT];
    wire spk_mute  = spkvol_q[`AOSC_BIT_SPKMUTE];
    wire mmx_mute  = mmx_q[`AOSC_BIT_MMXMUTE];
    wire mono_output_pin_mute = mono_output_pin_q[`AOSC_BIT_MOUTMUTE];

    assign any_out_on = spk_p | spk_n | mono_on;

    always @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            SPEAKER_PLUS_PIN_DRIVE_OUT   <= 1'b0;
            SPEAKER_MINUS_PIN_DRIVE_OUT  <= 1'b0;
            SPEAKER_VOLUME_OUT           <= 6'h00;
            SPEAKER_ATTEN_OUT            <= 1'b0;
            SPEAKER_BOOST_SELECT_OUT     <= 1'b0;
            SPEAKER_PLUS_PIN_TIE_OUT     <= 1'b0;
            SPEAKER_MINUS_PIN_TIE_OUT    <= 1'b0;
            SPEAKER_TIE_HI_OUT           <= 1'b0;
            MONO_OUTPUT_PIN_DRIVE_OUT    <= 1'b0;
            MONO_ATTEN_OUT               <= 1'b0;
            MONO_BOOST_SELECT_OUT        <= 1'b0;
            MONO_OUTPUT_PIN_TIE_OUT      <= 1'b0;
            MONO_TIE_HI_OUT              <= 1'b0;
            REF_TIEOFF_BUFFER_ON_OUT     <= 1'b0;
            BOOSTED_TIEOFF_BUFFER_ON_OUT <= 1'b0;
            TIEOFF_HIGH_Z_OUT            <= 1'b0;
            INPUT_TIE_OUT                <= {N_INPUTS{1'b0}};
        end else begin
            // each terminal drives only with mixer, its enable, no mute
            SPEAKER_PLUS_PIN_DRIVE_OUT  <= spk_mx & spk_p & ~spk_mute;
            SPEAKER_MINUS_PIN_DRIVE_OUT <= spk_mx & spk_n & ~spk_mute;
            SPEAKER_VOLUME_OUT          <= spkvol_q[5:0];
            SPEAKER_ATTEN_OUT           <= att_q[`AOSC_BIT_SPEAKER_ATTEN];
            SPEAKER_BOOST_SELECT_OUT    <= bst_q[`AOSC_BIT_SPEAKER_BOOST_SELECT];
            MONO_OUTPUT_PIN_DRIVE_OUT   <= mono_mx & mono_on & ~mmx_mute
                                           & ~mono_output_pin_mute;
            MONO_ATTEN_OUT              <= att_q[`AOSC_BIT_MONOATT];
            MONO_BOOST_SELECT_OUT       <= bst_q[`AOSC_BIT_MONOBST];
            // unused or muted pins held at their dc level
            SPEAKER_PLUS_PIN_TIE_OUT  <= ~(spk_mx & spk_p & ~spk_mute);
            SPEAKER_MINUS_PIN_TIE_OUT <= ~(spk_mx & spk_n & ~spk_mute);
            MONO_OUTPUT_PIN_TIE_OUT   <= ~(mono_mx & mono_on & ~mmx_mute
                                           & ~mono_output_pin_mute);
            SPEAKER_TIE_HI_OUT <= bst_q[`AOSC_BIT_SPEAKER_BOOST_SELECT];
            MONO_TIE_HI_OUT    <= bst_q[`AOSC_BIT_MONOBST];
            REF_TIEOFF_BUFFER_ON_OUT     <= buf_q[`AOSC_BIT_REFBUF];
            BOOSTED_TIEOFF_BUFFER_ON_OUT <= buf_q[`AOSC_BIT_BSTBUF];
            TIEOFF_HIGH_Z_OUT            <= hiz_q;
            // inputs always tie to 1.0x, each one when its own switch is open
            INPUT_TIE_OUT <= ~insw_q;
        end
    end

    // ------------------------------------------------------------
    // depop delay after enabling outputs
    // ------------------------------------------------------------
    aosc_depop_timer #(
        .CYC_W    (24),
        .BASE_CYC (DEPOP_CYC)
    ) u_depop (
        .clk_in   (REF_CLK_IN),
        .rst_n_in (RST_N_IN),
        .start_in (pwr_wr_q & any_out_on),
        .srate_in (srate_q),
        .done_out (depop_done)
    );
    // host waits for this before audio data
    assign DEPOP_DONE_OUT = depop_done & any_out_on;

    // ------------------------------------------------------------
    // playback boost
    // ------------------------------------------------------------
    aosc_gain_boost #(
        .W (SAMPLE_W)
    ) u_boost (
        .clk_in       (REF_CLK_IN),
        .rst_n_in     (RST_N_IN),
        .level_in     (lim_q[3:0]),
        .lim_en_in    (lim_q[`AOSC_BIT_LIMEN]),
        .below_thr_in (LIM_BELOW_THR_IN),
        .valid_in     (PLAY_VALID_IN),
        .sample_in    (PLAY_SAMPLE_IN),
        .sample_out   (PLAY_SAMPLE_OUT),
        .valid_out    (PLAY_VALID_OUT)
    );
endmodule
`default_nettype wire

/* tb/aosc_top_sva.sv */
// concurrent checks on the output stage control ports
`timescale 1ns/10ps
`default_nettype none
module aosc_top_sva #(
    parameter N_INPUTS = 4
) (
    // clock, reset and register port
    input wire logic                REF_CLK_IN,
    input wire logic                RST_N_IN,
    input wire logic [6:0]          REG_ADDR_IN,
    input wire logic [8:0]          REG_WDATA_IN,
    input wire logic                REG_WR_IN,
    // playback
    input wire logic                PLAY_VALID_IN,
    input wire logic                PLAY_VALID_OUT,
    // output controls
    input wire logic                SPEAKER_PLUS_PIN_DRIVE_OUT,
    input wire logic                SPEAKER_MINUS_PIN_DRIVE_OUT,
    input wire logic [5:0]          SPEAKER_VOLUME_OUT,
    input wire logic                SPEAKER_ATTEN_OUT,
    input wire logic                SPEAKER_BOOST_SELECT_OUT,
    input wire logic                SPEAKER_PLUS_PIN_TIE_OUT,
    input wire logic                SPEAKER_MINUS_PIN_TIE_OUT,
    input wire logic                SPEAKER_TIE_HI_OUT,
    input wire logic                MONO_OUTPUT_PIN_DRIVE_OUT,
    input wire logic                MONO_ATTEN_OUT,
    input wire logic                MONO_BOOST_SELECT_OUT,
    input wire logic                MONO_OUTPUT_PIN_TIE_OUT,
    input wire logic                MONO_TIE_HI_OUT,
    input wire logic                REF_TIEOFF_BUFFER_ON_OUT,
    input wire logic                BOOSTED_TIEOFF_BUFFER_ON_OUT,
    input wire logic                TIEOFF_HIGH_Z_OUT,
    input wire logic [N_INPUTS-1:0] INPUT_TIE_OUT,
    input wire logic                DEPOP_DONE_OUT
);
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_vol;
        REG_WR_IN && REG_ADDR_IN == 7'h36 |->
            ##2 SPEAKER_VOLUME_OUT == $past(REG_WDATA_IN[5:0], 2);
    endproperty
    a_vol: assert property (p_vol) else $error("volume mismatch");
    property p_att;
        REG_WR_IN && REG_ADDR_IN == 7'h28 |-> ##2
            SPEAKER_ATTEN_OUT == $past(REG_WDATA_IN[1], 2) &&
            MONO_ATTEN_OUT == $past(REG_WDATA_IN[2], 2);
    endproperty
    a_att: assert property (p_att) else $error("atten mismatch");
    property p_bst;
        REG_WR_IN && REG_ADDR_IN == 7'h31 |-> ##2
            SPEAKER_BOOST_SELECT_OUT == $past(REG_WDATA_IN[2], 2) &&
            MONO_BOOST_SELECT_OUT == $past(REG_WDATA_IN[3], 2);
    endproperty
    a_bst: assert property (p_bst) else $error("boost mismatch");
    property p_tiehi;
        SPEAKER_TIE_HI_OUT == SPEAKER_BOOST_SELECT_OUT &&
            MONO_TIE_HI_OUT == MONO_BOOST_SELECT_OUT;
    endproperty
    a_tiehi: assert property (p_tiehi) else $error("tie level");
    property p_buf;
        REG_WR_IN && REG_ADDR_IN == 7'h01 |-> ##2
            REF_TIEOFF_BUFFER_ON_OUT == $past(REG_WDATA_IN[2], 2) &&
            BOOSTED_TIEOFF_BUFFER_ON_OUT == $past(REG_WDATA_IN[8], 2);
    endproperty
    a_buf: assert property (p_buf) else $error("buffer enable");
    property p_hiz;
        REG_WR_IN && REG_ADDR_IN == 7'h50 |->
            ##2 TIEOFF_HIGH_Z_OUT == $past(REG_WDATA_IN[0], 2);
    endproperty
    a_hiz: assert property (p_hiz) else $error("tie impedance");
    property p_intie;
        REG_WR_IN && REG_ADDR_IN == 7'h51 |-> ##2
            INPUT_TIE_OUT == ~$past(REG_WDATA_IN[N_INPUTS-1:0], 2);
    endproperty
    a_intie: assert property (p_intie) else $error("input tie");
    property p_smute;
        REG_WR_IN && REG_ADDR_IN == 7'h36 && REG_WDATA_IN[6] |-> ##2
            !SPEAKER_PLUS_PIN_DRIVE_OUT && !SPEAKER_MINUS_PIN_DRIVE_OUT &&
            SPEAKER_PLUS_PIN_TIE_OUT && SPEAKER_MINUS_PIN_TIE_OUT;
    endproperty
    a_smute: assert property (p_smute) else $error("speaker mute");
    property p_mono;
        MONO_OUTPUT_PIN_DRIVE_OUT |-> !MONO_OUTPUT_PIN_TIE_OUT;
    endproperty
    a_mono: assert property (p_mono) else $error("mono drive tie");
    property p_play;
        PLAY_VALID_OUT == $past(PLAY_VALID_IN);
    endproperty
    a_play: assert property (p_play) else $error("playback valid");
    c_spk: cover property (REG_WR_IN && REG_ADDR_IN == 7'h03);
    c_done: cover property ($rose(DEPOP_DONE_OUT));
    c_play: cover property (PLAY_VALID_OUT);
endmodule
bind aosc_top aosc_top_sva #(.N_INPUTS(N_INPUTS)) u_sva (
    .REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN),
    .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN),
    .REG_WR_IN(REG_WR_IN), .PLAY_VALID_IN(PLAY_VALID_IN),
    .PLAY_VALID_OUT(PLAY_VALID_OUT),
    .SPEAKER_PLUS_PIN_DRIVE_OUT(SPEAKER_PLUS_PIN_DRIVE_OUT),
    .SPEAKER_MINUS_PIN_DRIVE_OUT(SPEAKER_MINUS_PIN_DRIVE_OUT),
    .SPEAKER_VOLUME_OUT(SPEAKER_VOLUME_OUT),
    .SPEAKER_ATTEN_OUT(SPEAKER_ATTEN_OUT),
    .SPEAKER_BOOST_SELECT_OUT(SPEAKER_BOOST_SELECT_OUT),
    .SPEAKER_PLUS_PIN_TIE_OUT(SPEAKER_PLUS_PIN_TIE_OUT),
    .SPEAKER_MINUS_PIN_TIE_OUT(SPEAKER_MINUS_PIN_TIE_OUT),
    .SPEAKER_TIE_HI_OUT(SPEAKER_TIE_HI_OUT),
    .MONO_OUTPUT_PIN_DRIVE_OUT(MONO_OUTPUT_PIN_DRIVE_OUT),
    .MONO_ATTEN_OUT(MONO_ATTEN_OUT),
    .MONO_BOOST_SELECT_OUT(MONO_BOOST_SELECT_OUT),
    .MONO_OUTPUT_PIN_TIE_OUT(MONO_OUTPUT_PIN_TIE_OUT),
    .MONO_TIE_HI_OUT(MONO_TIE_HI_OUT),
    .REF_TIEOFF_BUFFER_ON_OUT(REF_TIEOFF_BUFFER_ON_OUT),
    .BOOSTED_TIEOFF_BUFFER_ON_OUT(BOOSTED_TIEOFF_BUFFER_ON_OUT),
    .TIEOFF_HIGH_Z_OUT(TIEOFF_HIGH_Z_OUT), .INPUT_TIE_OUT(INPUT_TIE_OUT),
    .DEPOP_DONE_OUT(DEPOP_DONE_OUT));
`default_nettype wire

/* tb/tb.sv */
// random and corner-case bench for the output stage control
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam DEP = 20;
    reg clk = 0, rst_n = 0, wr = 0, rd = 0, pv = 0, below = 0;
    reg [6:0] addr = 0;
    reg [8:0] wd = 0;
    reg signed [15:0] ps = 0;
    wire [8:0] rdata;
    wire signed [15:0] pout;
    wire [3:0] in_tie;
    wire [5:0] vol;
    wire pvo, sp, sn, sa, sb, spt, snt, sth, md, ma, mb, mt, mth, rb, bb;
    wire hz, done;
    integer error_cnt = 0, num_checks = 0, seed = 32'heb54, i, j, n;
    reg [8:0] mir [0:127];
    reg [6:0] amap [0:8];
    always #12.5 clk = ~clk;
    aosc_top #(.DEPOP_CYC(DEP)) uut (.REF_CLK_IN(clk), .RST_N_IN(rst_n),
        .REG_ADDR_IN(addr), .REG_WDATA_IN(wd), .REG_WR_IN(wr),
        .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .PLAY_VALID_IN(pv),
        .PLAY_SAMPLE_IN(ps), .LIM_BELOW_THR_IN(below),
        .PLAY_VALID_OUT(pvo), .PLAY_SAMPLE_OUT(pout),
        .SPEAKER_PLUS_PIN_DRIVE_OUT(sp), .SPEAKER_MINUS_PIN_DRIVE_OUT(sn),
        .SPEAKER_VOLUME_OUT(vol), .SPEAKER_ATTEN_OUT(sa),
        .SPEAKER_BOOST_SELECT_OUT(sb), .SPEAKER_PLUS_PIN_TIE_OUT(spt),
        .SPEAKER_MINUS_PIN_TIE_OUT(snt), .SPEAKER_TIE_HI_OUT(sth),
        .MONO_OUTPUT_PIN_DRIVE_OUT(md), .MONO_ATTEN_OUT(ma),
        .MONO_BOOST_SELECT_OUT(mb), .MONO_OUTPUT_PIN_TIE_OUT(mt),
        .MONO_TIE_HI_OUT(mth), .REF_TIEOFF_BUFFER_ON_OUT(rb),
        .BOOSTED_TIEOFF_BUFFER_ON_OUT(bb), .TIEOFF_HIGH_Z_OUT(hz),
        .INPUT_TIE_OUT(in_tie), .DEPOP_DONE_OUT(done));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task check(input [15:0] seen, input [15:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d errors %0d", num_checks, error_cnt);
            if (error_cnt == 0 && num_checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task wr_reg(input [6:0] a, input [8:0] d);
        begin
            @(posedge clk);
            wr <= 1; addr <= a; wd <= d;
            @(posedge clk);
            wr <= 0;
            if (a != 7'h52 && a != 7'h7f) mir[a] = d;
            if (a == 7'h50) mir[a] = d & 9'h001;
            if (a == 7'h51) mir[a] = d & 9'h00f;
        end
    endtask
    task rd_reg(input [6:0] a, input [8:0] exp);
        begin
            @(posedge clk);
            rd <= 1; addr <= a;
            @(posedge clk);
            rd <= 0;
            #1 check(rdata, exp);
        end
    endtask
    task settle;
        begin
            repeat (2) @(posedge clk);
            #1;
        end
    endtask
    task chk_out;
        reg p, m, q;
        begin
            p = mir[3][2] & ~mir[8'h36][6];
            m = mir[3][3] & mir[3][7] & ~mir[8'h38][6] & ~mir[8'h45][4];
            check({sp, sn}, {p & mir[3][5], p & mir[3][6]});
            check({spt, snt}, {~(p & mir[3][5]), ~(p & mir[3][6])});
            check({md, mt}, {m, ~m});
            check({vol, sa, ma}, {mir[8'h36][5:0], mir[8'h28][1],
                mir[8'h28][2]});
            check({sb, sth, mb, mth}, {mir[8'h31][2], mir[8'h31][2],
                mir[8'h31][3], mir[8'h31][3]});
            check({rb, bb, hz}, {mir[1][2], mir[1][8], mir[8'h50][0]});
            check(in_tie, {~mir[8'h51][3:0]});
        end
    endtask
    function integer gq8(input integer db);
        integer t [0:12];
        begin
            t = '{256, 287, 322, 362, 406, 455, 511, 573, 643, 722, 810,
                908, 1019};
            gq8 = t[db > 12 ? 12 : db];
        end
    endfunction
    task play(input integer db);
        integer e;
        begin
            @(posedge clk);
            pv <= 1; ps <= $random(seed) % 4000;
            @(posedge clk);
            pv <= 0;
            #1 e = (ps * gq8(db)) >>> 8;
            check(pvo, 1'b1);
            check((pout - e <= 1) && (e - pout <= 1), 1'b1);
        end
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        #(20000 * 25);
        error_cnt = error_cnt + 1;
        report_and_stop;
    end
    initial begin
        for (i = 0; i < 128; i = i + 1) mir[i] = 9'h000;
        amap = '{7'h01, 7'h03, 7'h28, 7'h31, 7'h36, 7'h38, 7'h45, 7'h50,
            7'h51};
        repeat (3) @(posedge clk);
        rst_n <= 1;
        for (i = 0; i < 9; i = i + 1) rd_reg(amap[i], 9'h000);
        wr_reg(7'h03, 9'h064);
        settle;
        chk_out;
        for (i = 0; i < 60; i = i + 1) begin
            j = $unsigned($random(seed)) % 9;
            wr_reg(amap[j], $random(seed));
            settle;
            chk_out;
            rd_reg(amap[j], mir[amap[j]]);
        end
        wr_reg(7'h7f, 9'h1ff);
        rd_reg(7'h7f, 9'h000);
        wr_reg(7'h36, 9'h000);
        wr_reg(7'h38, 9'h000);
        wr_reg(7'h45, 9'h000);
        for (j = 0; j < 3; j = j + 2) begin
            wr_reg(7'h07, j << 1);
            wr_reg(7'h51, 9'h000);
            wr_reg(7'h03, 9'h0ec);
            // let the restart clear a done left from earlier enables
            @(posedge clk);
            #1 n = 1;
            while (done !== 1'b1 && n < 400) begin
                @(posedge clk);
                #1 n = n + 1;
            end
            check(n >= DEP * (j + 1) - 3 && n <= DEP * (j + 1) + 3, 1);
            rd_reg(7'h52, 9'h011);
        end
        for (j = 0; j < 3; j = j + 1)
            for (i = 0; i < 16; i = i + 1) begin
                wr_reg(7'h19, {j != 0, 4'h0, i[3:0]});
                below <= (j == 2);
                settle;
                play(j == 1 ? 0 : i);
            end
        report_and_stop;
    end
endmodule
`default_nettype wire
